/* File: rtl/iab_baud.sv */
// half-period tick generator for master scl
`timescale 1ns/1ps
module iab_baud
  import iab_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic run,
  input wire logic [7:0] divider,
  output logic tick
);
  logic [8:0] cnt;
  logic [8:0] next_cnt;
  logic next_tick;

  // ---------------------------------------------------------------
  // reload with 2*div+1 so each half lasts 2*(div+1) cycles
  // ---------------------------------------------------------------
  always_comb begin
    next_cnt = cnt;
    next_tick = 1'b0;
    if (!run) begin
      next_cnt = {divider, 1'b1};
    end else if (cnt == 9'h000) begin
      next_cnt = {divider, 1'b1};
      next_tick = 1'b1;
    end else begin
      next_cnt = cnt - 9'h001;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 9'h000;
      tick <= 1'b0;
    end else begin
      cnt <= next_cnt;
      tick <= next_tick;
    end
  end
endmodule

/* File: rtl/iab_match.sv */
// masked slave address comparison for 7-bit and 10-bit modes
`timescale 1ns/1ps
module iab_match
  import iab_pkg::*;
(
  input wire logic ten_bit,
  input wire logic high_done,
  input wire logic [7:0] rx_byte,
  input wire logic [7:0] addr,
  input wire logic [7:0] mask,
  output logic match
);
  // ---------------------------------------------------------------
  // bit compare only where mask is set
  // ---------------------------------------------------------------
  function automatic logic [7:0] diff(input logic [7:0] a, input logic [7:0] b,
                                      input logic [7:0] m);
    diff = (a ^ b) & m;
  endfunction

  logic [7:0] d;

  always_comb begin
    d = diff(rx_byte, addr, mask);
    if (!ten_bit) begin
      match = (d[7:1] == 7'h00);
    end else if (!high_done) begin
      match = (rx_byte[7:3] == IAB_TEN_BIT_PREFIX) && (d[2:1] == 2'h0);
    end else begin
      match = (d == 8'h00);
    end
  end
endmodule

/* File: rtl/iab_pkg.sv */
// shared constants for the i2c address, baud and buffer block
package iab_pkg;
  // ---------------------------------------------------------------
  // register byte offsets
  // ---------------------------------------------------------------
  localparam logic [7:0] IAB_OFF_ADDR = 8'h00;
  localparam logic [7:0] IAB_OFF_BUF = 8'h04;
  localparam logic [7:0] IAB_OFF_MASK = 8'h08;
  localparam logic [7:0] IAB_OFF_CTRL = 8'h0c;
  localparam logic [7:0] IAB_OFF_STAT = 8'h10;
  // ---------------------------------------------------------------
  // reset values
  // ---------------------------------------------------------------
  localparam logic [7:0] IAB_RST_ADDR = 8'h00;
  localparam logic [7:0] IAB_RST_MASK = 8'hff;
  localparam logic [1:0] IAB_RST_MODE = 2'h0;
  // ---------------------------------------------------------------
  // mode codes in control bits 1:0
  // ---------------------------------------------------------------
  localparam logic [1:0] IAB_MODE_OFF = 2'h0;
  localparam logic [1:0] IAB_MODE_MASTER = 2'h1;
  localparam logic [1:0] IAB_MODE_SLV7 = 2'h2;
  localparam logic [1:0] IAB_MODE_SLV10 = 2'h3;
  // ---------------------------------------------------------------
  // status bit positions
  // ---------------------------------------------------------------
  localparam int IAB_STAT_BUSY = 0;
  localparam int IAB_STAT_MATCH = 1;
  localparam int IAB_STAT_FULL = 2;
  localparam int IAB_STAT_NACK = 3;
  // ---------------------------------------------------------------
  // protocol figures
  // ---------------------------------------------------------------
  localparam logic [4:0] IAB_TEN_BIT_PREFIX = 5'h1e;
  localparam logic [3:0] IAB_BITS_PER_BYTE = 4'h8;
  // ---------------------------------------------------------------
  // engine states
  // ---------------------------------------------------------------
  typedef enum logic [3:0] {
    IAB_ST_IDLE = 4'h0,
    IAB_ST_M_START = 4'h1,
    IAB_ST_M_LOW = 4'h2,
    IAB_ST_M_HIGH = 4'h3,
    IAB_ST_M_STOP_LO = 4'h4,
    IAB_ST_M_STOP_HI = 4'h5,
    IAB_ST_S_ADDR = 4'h6,
    IAB_ST_S_ACK = 4'h7,
    IAB_ST_S_DATA = 4'h8,
    IAB_ST_S_SKIP = 4'h9
  } iab_state_t;
endpackage

/* File: rtl/iab_top.sv */
// i2c address/baud register, data buffer and byte engine with apb access
`timescale 1ns/1ps
module iab_top
  import iab_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe
);
  // ---------------------------------------------------------------
  // pin synchronisers and bus events
  // ---------------------------------------------------------------
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic scl_rise, scl_fall, bus_start, bus_stop;

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_s1 <= scl_i;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= sda_i;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
    end
  end

  assign scl_rise = scl_s2 && !scl_d;
  assign scl_fall = !scl_s2 && scl_d;
  assign bus_start = scl_s2 && scl_d && sda_d && !sda_s2;
  assign bus_stop = scl_s2 && scl_d && !sda_d && sda_s2;

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  logic [7:0] divider, next_divider;
  logic [7:0] mask, next_mask;
  logic [1:0] mode, next_mode;
  logic [7:0] buffer, next_buffer;
  logic buf_full, next_buf_full;
  logic nack, next_nack;
  logic matched, next_matched;
  logic high_done, next_high_done;
  iab_state_t st, next_st;
  logic [3:0] bitcnt, next_bitcnt;
  logic [7:0] shreg, next_shreg;
  logic next_scl_oe, next_sda_oe;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  logic tick, baud_run, addr_match, acc, wr_done, rd_done, mapped;
  logic busy, is_slave, rw_ok;
  logic [7:0] rx_byte;

  assign acc = psel && penable;
  assign wr_done = acc && pready && pwrite;
  assign rd_done = acc && pready && !pwrite;
  assign busy = (st != IAB_ST_IDLE);
  assign is_slave = (mode == IAB_MODE_SLV7) || (mode == IAB_MODE_SLV10);
  // 10-bit low byte carries address bit 0, no direction bit
  assign rw_ok = !shreg[0] || ((mode == IAB_MODE_SLV10) && high_done);
  assign rx_byte = shreg;
  assign baud_run = (st == IAB_ST_M_START) || (st == IAB_ST_M_LOW) ||
                    (st == IAB_ST_M_HIGH) || (st == IAB_ST_M_STOP_LO) ||
                    (st == IAB_ST_M_STOP_HI);
  assign mapped = (paddr == IAB_OFF_ADDR) || (paddr == IAB_OFF_BUF) ||
                  (paddr == IAB_OFF_MASK) || (paddr == IAB_OFF_CTRL) ||
                  (paddr == IAB_OFF_STAT);

  iab_baud u_baud (
    .sys_clk(sys_clk),
    .rst_n(rst_n),
    .run(baud_run),
    .divider(divider),
    .tick(tick)
  );

  iab_match u_match (
    .ten_bit(mode == IAB_MODE_SLV10),
    .high_done(high_done),
    .rx_byte(rx_byte),
    .addr(divider),
    .mask(mask),
    .match(addr_match)
  );

  // ---------------------------------------------------------------
  // apb slave, one wait state
  // ---------------------------------------------------------------
  always_comb begin
    next_pready = 1'b0;
    next_pslverr = 1'b0;
    next_prdata = prdata;
    if (acc && !pready) begin
      next_pready = 1'b1;
      next_pslverr = !mapped;
      unique case (paddr)
        IAB_OFF_ADDR: next_prdata = {24'h000000, divider};
        IAB_OFF_BUF: next_prdata = {24'h000000, buffer};
        IAB_OFF_MASK: next_prdata = {24'h000000, mask};
        IAB_OFF_CTRL: next_prdata = {30'h0, mode};
        IAB_OFF_STAT: next_prdata = {28'h0000000, nack, buf_full, matched, busy};
        default: next_prdata = 32'h00000000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // registers and byte engine
  // ---------------------------------------------------------------
  always_comb begin
    next_divider = divider;
    next_mask = mask;
    next_mode = mode;
    next_buffer = buffer;
    next_buf_full = buf_full;
    next_nack = nack;
    next_matched = matched;
    next_high_done = high_done;
    next_st = st;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_scl_oe = scl_oe;
    next_sda_oe = sda_oe;

    // software side
    if (rd_done && paddr == IAB_OFF_BUF) begin
      next_buf_full = 1'b0;
    end
    if (wr_done) begin
      unique case (paddr)
        IAB_OFF_ADDR: next_divider = pwdata[7:0];
        IAB_OFF_MASK: next_mask = pwdata[7:0];
        IAB_OFF_CTRL: next_mode = pwdata[1:0];
        IAB_OFF_BUF: begin
          if (!busy) begin
            next_buffer = pwdata[7:0];
            if (mode == IAB_MODE_MASTER) begin
              next_shreg = pwdata[7:0];
              next_sda_oe = 1'b1;
              next_nack = 1'b0;
              next_st = IAB_ST_M_START;
            end
          end
        end
        default: begin
        end
      endcase
    end

    // engine
    unique case (st)
      IAB_ST_IDLE: begin
        if (is_slave && bus_start) begin
          next_st = IAB_ST_S_ADDR;
          next_bitcnt = 4'h0;
          next_matched = 1'b0;
          next_high_done = 1'b0;
        end
      end
      IAB_ST_M_START: begin
        if (tick) begin
          next_scl_oe = 1'b1;
          next_sda_oe = !shreg[7];
          next_bitcnt = 4'h0;
          next_st = IAB_ST_M_LOW;
        end
      end
      IAB_ST_M_LOW: begin
        if (tick) begin
          next_scl_oe = 1'b0;
          next_st = IAB_ST_M_HIGH;
        end
      end
      IAB_ST_M_HIGH: begin
        if (tick) begin
          next_scl_oe = 1'b1;
          if (bitcnt == IAB_BITS_PER_BYTE) begin
            next_nack = sda_s2;
            next_sda_oe = 1'b1;
            next_st = IAB_ST_M_STOP_LO;
          end else begin
            next_bitcnt = bitcnt + 4'h1;
            next_shreg = {shreg[6:0], 1'b0};
            next_sda_oe = (bitcnt == IAB_BITS_PER_BYTE - 4'h1) ? 1'b0 : !shreg[6];
            next_st = IAB_ST_M_LOW;
          end
        end
      end
      IAB_ST_M_STOP_LO: begin
        if (tick) begin
          next_scl_oe = 1'b0;
          next_st = IAB_ST_M_STOP_HI;
        end
      end
      IAB_ST_M_STOP_HI: begin
        if (tick) begin
          next_sda_oe = 1'b0;
          next_st = IAB_ST_IDLE;
        end
      end
      IAB_ST_S_ADDR, IAB_ST_S_DATA: begin
        if (scl_rise && bitcnt != IAB_BITS_PER_BYTE) begin
          next_shreg = {shreg[6:0], sda_s2};
          next_bitcnt = bitcnt + 4'h1;
        end else if (scl_fall && bitcnt == IAB_BITS_PER_BYTE) begin
          if (st == IAB_ST_S_DATA) begin
            next_buffer = shreg;
            next_buf_full = 1'b1;
            next_sda_oe = 1'b1;
            next_st = IAB_ST_S_ACK;
          end else if (addr_match && rw_ok) begin
            next_sda_oe = 1'b1;
            next_st = IAB_ST_S_ACK;
            if (mode == IAB_MODE_SLV10 && !high_done) begin
              next_high_done = 1'b1;
            end else begin
              next_matched = 1'b1;
            end
          end else begin
            next_st = IAB_ST_S_SKIP;
          end
        end
      end
      IAB_ST_S_ACK: begin
        if (scl_fall) begin
          next_sda_oe = 1'b0;
          next_bitcnt = 4'h0;
          next_st = matched ? IAB_ST_S_DATA : IAB_ST_S_ADDR;
        end
      end
      IAB_ST_S_SKIP: begin
      end
      default: begin
        next_st = IAB_ST_IDLE;
      end
    endcase

    // bus conditions seen by the slave
    if (is_slave && (st != IAB_ST_IDLE)) begin
      if (bus_stop) begin
        next_st = IAB_ST_IDLE;
        next_sda_oe = 1'b0;
      end else if (bus_start) begin
        next_st = IAB_ST_S_ADDR;
        next_bitcnt = 4'h0;
        next_matched = 1'b0;
        next_high_done = 1'b0;
        next_sda_oe = 1'b0;
      end
    end
    if (next_mode == IAB_MODE_OFF || (next_mode != mode)) begin
      next_st = IAB_ST_IDLE;
      next_scl_oe = 1'b0;
      next_sda_oe = 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      divider <= IAB_RST_ADDR;
      mask <= IAB_RST_MASK;
      mode <= IAB_RST_MODE;
      buf_full <= 1'b0;
      nack <= 1'b0;
      matched <= 1'b0;
      high_done <= 1'b0;
      st <= IAB_ST_IDLE;
      bitcnt <= 4'h0;
      shreg <= 8'h00;
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      divider <= next_divider;
      mask <= next_mask;
      mode <= next_mode;
      buf_full <= next_buf_full;
      nack <= next_nack;
      matched <= next_matched;
      high_done <= next_high_done;
      st <= next_st;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      scl_oe <= next_scl_oe;
      sda_oe <= next_sda_oe;
      scl_o <= 1'b0;
      sda_o <= 1'b0;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ---------------------------------------------------------------
  // data buffer, no reset
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    buffer <= next_buffer;
  end
endmodule

/* File: test/iab_far.sv */
// far side model: i2c slave for device master, i2c master for device slave
`timescale 1ns/1ps
module iab_far (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_pull,
  output logic sda_pull
);
  logic ack_en;
  logic slave_en;
  logic act;
  logic [7:0] rx;
  logic [7:0] got;
  int cnt;
  initial begin
    scl_pull = 1'b0;
    sda_pull = 1'b0;
    ack_en = 1'b1;
    slave_en = 1'b0;
    act = 1'b0;
    cnt = 0;
    rx = 8'h00;
  end
  // ------
  // slave monitor, msb first, ack on ninth clock
  // ------
  // let a simultaneous scl fall settle before judging start or stop
  always @(negedge sda_line) begin
    #1;
    if (scl_line === 1'b1) begin
      act = 1'b1;
      cnt = 0;
    end
  end
  always @(posedge sda_line) begin
    #1;
    if (scl_line === 1'b1) act = 1'b0;
  end
  always @(posedge scl_line) if (act) begin
    if (cnt < 8) rx = {rx[6:0], sda_line};
    cnt = cnt + 1;
    if (cnt == 8) got = rx;
  end
  always @(negedge scl_line) if (act) begin
    if (cnt == 8 && slave_en) sda_pull = ack_en;
    if (cnt == 9) begin
      if (slave_en) sda_pull = 1'b0;
      cnt = 0;
    end
  end
  // ------
  // master side, 160 ns bit period
  // ------
  task begin_frame;
    sda_pull = 1'b1;
    #80 scl_pull = 1'b1;
    #40;
  endtask
  task put_byte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      sda_pull = ~b[i];
      #40 scl_pull = 1'b0;
      #80 scl_pull = 1'b1;
      #40;
    end
    sda_pull = 1'b0;
    #40 scl_pull = 1'b0;
    #40 ack = ~sda_line;
    #40 scl_pull = 1'b1;
    #40;
  endtask
  task end_frame;
    sda_pull = 1'b1;
    #40 scl_pull = 1'b0;
    #80 sda_pull = 1'b0;
    #80;
  endtask
endmodule

/* File: test/iab_top_sva.sv */
// assertion checker for the i2c address, baud and buffer block
`timescale 1ns/1ps
module iab_top_sva
  import iab_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic scl_i,
  input wire logic scl_o,
  input wire logic scl_oe,
  input wire logic sda_i,
  input wire logic sda_o,
  input wire logic sda_oe
);
  // ------
  // divider shadow and scl hold counter
  // ------
  logic [7:0] div_q;
  logic [7:0] next_div_q;
  logic [9:0] hold;
  logic [9:0] next_hold;
  logic commit;
  logic mapped;
  assign commit = psel && penable && pready;
  assign mapped = paddr inside {IAB_OFF_ADDR, IAB_OFF_BUF, IAB_OFF_MASK, IAB_OFF_CTRL,
                                IAB_OFF_STAT};
  always_comb begin
    next_div_q = div_q;
    if (commit && pwrite && paddr == IAB_OFF_ADDR) begin
      next_div_q = pwdata[7:0];
    end
    next_hold = scl_oe ? hold + 10'h1 : 10'h0;
  end
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_q <= IAB_RST_ADDR;
      hold <= 10'h0;
    end else begin
      div_q <= next_div_q;
      hold <= next_hold;
    end
  end
  // ------
  // properties
  // ------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  apb_wait_a: assert property (psel && penable && !pready |=> pready)
    else $error("no ready after access");
  ready_pulse_a: assert property (pready |=> !pready) else $error("ready longer than one cycle");
  err_ready_a: assert property (pslverr |-> pready) else $error("error without ready");
  map_err_a: assert property (commit |-> pslverr == !mapped) else $error("error flag wrong");
  read_upper_a: assert property (commit && !pwrite |-> prdata[31:8] == 24'h0)
    else $error("upper read bits set");
  open_drain_a: assert property (scl_o == 1'b0 && sda_o == 1'b0) else $error("pin driven high");
  reset_idle_a: assert property ($rose(rst_n) |-> !pready && !scl_oe && !sda_oe)
    else $error("outputs busy after reset");
  scl_half_a: assert property ($fell(scl_oe) |-> hold == {1'b0, div_q, 1'b0} + 10'h2)
    else $error("scl low half wrong length");
endmodule
bind iab_top iab_top_sva chk (
  .sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .scl_i(scl_i), .scl_o(scl_o), .scl_oe(scl_oe), .sda_i(sda_i), .sda_o(sda_o),
  .sda_oe(sda_oe)
);

/* File: test/test_iab_top.sv */
// self-checking bench for the i2c address, baud and buffer block
`timescale 1ns/1ps
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin mismatches++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module test_iab_top
  import iab_pkg::*;
;
  logic sys_clk, rst_n, psel, penable, pwrite, pready, pslverr, err, ack;
  logic [7:0] paddr, div;
  logic [31:0] pwdata, prdata, rd;
  logic scl_o, scl_oe, sda_o, sda_oe, scl_pull, sda_pull;
  wire logic scl_line = ~(scl_oe | scl_pull);
  wire logic sda_line = ~(sda_oe | sda_pull);
  int mismatches, compares, cyc;
  time t_rise, per;
  initial begin
    sys_clk = 1'b0;
    forever #5 sys_clk = ~sys_clk;
  end
  iab_top dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .scl_i(scl_line), .scl_o(scl_o), .scl_oe(scl_oe),
    .sda_i(sda_line), .sda_o(sda_o), .sda_oe(sda_oe));
  iab_far far (.scl_line(scl_line), .sda_line(sda_line), .scl_pull(scl_pull),
    .sda_pull(sda_pull));
  always @(posedge scl_line) begin
    per = $time - t_rise;
    t_rise = $time;
  end
  // ------
  // apb master and helpers
  // ------
  task apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h0, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task rdchk(input logic [7:0] a, input logic [7:0] e, input logic ee);
    apb(1'b0, a, 8'h00);
    `CHK(rd, {24'h0, e})
    `CHK(err, ee)
  endtask
  task wait_idle;
    do apb(1'b0, IAB_OFF_STAT, 8'h00); while (rd[IAB_STAT_BUSY] === 1'b1);
  endtask
  task xfer(input logic [7:0] b, input logic e);
    far.put_byte(b, ack);
    `CHK(ack, e)
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc = cyc + 1;
    if (cyc == 60000) begin
      mismatches++;
      wrap_up;
    end
  end
  // ------
  // main sequence
  // ------
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    rst_n = 1'b0;
    mismatches = 0;
    compares = 0;
    cyc = 0;
    t_rise = 0;
    repeat (20) @(posedge sys_clk);
    rst_n <= 1'b1;
    rdchk(IAB_OFF_ADDR, IAB_RST_ADDR, 1'b0);
    rdchk(IAB_OFF_MASK, IAB_RST_MASK, 1'b0);
    rdchk(IAB_OFF_CTRL, {6'h0, IAB_RST_MODE}, 1'b0);
    apb(1'b1, IAB_OFF_STAT, 8'hff);
    rdchk(IAB_OFF_STAT, 8'h00, 1'b0);
    apb(1'b1, 8'h14, 8'h5a);
    `CHK(err, 1'b1)
    rdchk(8'h14, 8'h00, 1'b1);
    apb(1'b1, IAB_OFF_BUF, 8'ha5);
    rdchk(IAB_OFF_BUF, 8'ha5, 1'b0);
    $display("test registers done");
    far.slave_en = 1'b1;
    for (int i = 0; i < 2; i++) begin
      div = (i == 0) ? 8'h03 : 8'h0a;
      far.ack_en = (i == 0);
      apb(1'b1, IAB_OFF_ADDR, div);
      apb(1'b1, IAB_OFF_CTRL, {6'h0, IAB_MODE_MASTER});
      apb(1'b1, IAB_OFF_BUF, 8'h5a + i[7:0]);
      wait_idle;
      `CHK(far.got, 8'h5a + i[7:0])
      `CHK(rd[IAB_STAT_NACK], (i == 1))
      `CHK(per, 64'd40 * (div + 64'd1))
    end
    $display("test master done");
    far.slave_en = 1'b0;
    apb(1'b1, IAB_OFF_CTRL, {6'h0, IAB_MODE_SLV7});
    apb(1'b1, IAB_OFF_ADDR, 8'h85);
    far.begin_frame;
    xfer(8'h84, 1'b1);
    xfer(8'h3c, 1'b1);
    far.end_frame;
    rdchk(IAB_OFF_STAT, 8'h0e, 1'b0);
    rdchk(IAB_OFF_BUF, 8'h3c, 1'b0);
    far.begin_frame;
    xfer(8'h86, 1'b0);
    far.end_frame;
    apb(1'b1, IAB_OFF_MASK, 8'hfd);
    far.begin_frame;
    xfer(8'h86, 1'b1);
    far.end_frame;
    $display("test slave 7-bit done");
    apb(1'b1, IAB_OFF_MASK, 8'hff);
    apb(1'b1, IAB_OFF_CTRL, {6'h0, IAB_MODE_SLV10});
    apb(1'b1, IAB_OFF_ADDR, 8'h35);
    far.begin_frame;
    xfer({IAB_TEN_BIT_PREFIX, 2'b10, 1'b0}, 1'b1);
    xfer(8'h35, 1'b1);
    xfer(8'h99, 1'b1);
    far.end_frame;
    rdchk(IAB_OFF_BUF, 8'h99, 1'b0);
    rdchk(IAB_OFF_STAT, 8'h0a, 1'b0);
    far.begin_frame;
    xfer(8'he4, 1'b0);
    far.end_frame;
    far.begin_frame;
    xfer(8'hf2, 1'b0);
    far.end_frame;
    far.begin_frame;
    xfer(8'hf4, 1'b1);
    xfer(8'h34, 1'b0);
    far.end_frame;
    $display("test slave 10-bit done");
    wrap_up;
  end
endmodule
